// ===== hdl/tctp_cfg.svh
// tctp_cfg.svh: offsets, field positions, codes and reset values
// of the triple counter timer port.
// assumes: included by its bare name wherever a constant is needed.
`ifndef TCTP_CFG_SVH
`define TCTP_CFG_SVH

// ======================================================================
// register offsets on the 8-bit i/o bus
`define TCTP_ADDR_W        4
`define TCTP_OFF_IRQ_CLR   4'h6
`define TCTP_OFF_CTR_A     4'h8
`define TCTP_OFF_CTR_B     4'h9
`define TCTP_OFF_CTR_C     4'ha
`define TCTP_OFF_MODE_CMD  4'hb

// ======================================================================
// mode command fields
`define TCTP_SEL_MSB       7
`define TCTP_SEL_LSB       6
`define TCTP_ACC_MSB       5
`define TCTP_ACC_LSB       4
`define TCTP_MODE_MSB      3
`define TCTP_MODE_LSB      1
`define TCTP_BCD_BIT       0
`define TCTP_RB_NCOUNT_BIT 5
`define TCTP_RB_MASK_LSB   1

// counter select codes
`define TCTP_SEL_A         2'h0
`define TCTP_SEL_B         2'h1
`define TCTP_SEL_C         2'h2
`define TCTP_SEL_RBACK     2'h3

// byte access codes
`define TCTP_ACC_LATCH     2'h0
`define TCTP_ACC_LOW       2'h1
`define TCTP_ACC_HIGH      2'h2
`define TCTP_ACC_BOTH      2'h3

// operating mode codes
`define TCTP_M_TERM_INT    3'h0
`define TCTP_M_ONE_SHOT    3'h1
`define TCTP_M_RATE        3'h2
`define TCTP_M_SQUARE      3'h3
`define TCTP_M_SW_STROBE   3'h4
`define TCTP_M_HW_STROBE   3'h5

// ======================================================================
// count values and reset values
`define TCTP_CNT_ZERO      16'h0000
`define TCTP_CNT_ONE       16'h0001
`define TCTP_CNT_TWO       16'h0002
`define TCTP_BYTE_ZERO     8'h00
`define TCTP_RST_ACC       2'h3
`define TCTP_RST_MODE      3'h0
`define TCTP_NUM_CTR       3

`endif

// ===== hdl/tctp_pkg.sv
// tctp_pkg: state types of the triple counter timer port.
// assumes: constants come from tctp_cfg.svh.
package tctp_pkg;

   // ===================================================================
   // per counter state
   typedef struct packed {
      logic [15:0] count;    // live count
      logic [15:0] reload;   // loaded start value
      logic [15:0] latch;    // captured count
      logic        latched;  // read returns captured count
      logic [7:0]  wlow;     // low byte waiting for its high byte
      logic        wr_hi;    // next data write is the high byte
      logic        rd_hi;    // next data read is the high byte
      logic [1:0]  access;   // byte access pattern
      logic [2:0]  mode;     // operating mode
      logic        bcd;      // count in bcd
      logic        pend;     // start value waits for the next tick
      logic        armed;    // start value waits for a gate trigger
      logic        run;      // counting
      logic        gate_q;   // gate seen on the previous cycle
      logic        out;      // counter output
   } tctp_ctr_t;

   // ===================================================================
   // whole block state
   typedef struct packed {
      tctp_ctr_t [2:0] ctr;
      logic [7:0]      rdata;
      logic            irq;
      logic            out_c_q;
   } tctp_state_t;

endpackage : tctp_pkg

// ===== hdl/tctp_bus_if.sv
// tctp_bus_if: decoded access strobes from the bus decoder to the core.
// assumes: one clock; all strobes are single-cycle pulses.
`timescale 1ns/1ps
interface tctp_bus_if;
   logic       wr_irq_clr;  // write to the interrupt clear strobe
   logic       wr_cmd;      // write to the mode command register
   logic [2:0] wr_data;     // write to counter a, b, c data port
   logic [2:0] rd_data;     // read of counter a, b, c data port
   logic       rd_any;      // any read
   logic [7:0] wdata;       // write data

   modport dec (
      output wr_irq_clr, wr_cmd, wr_data, rd_data, rd_any, wdata
   );
   modport core (
      input  wr_irq_clr, wr_cmd, wr_data, rd_data, rd_any, wdata
   );
endinterface : tctp_bus_if

// ===== hdl/tctp_bus_dec.sv
// tctp_bus_dec: address decode of the 8-bit i/o bus into strobes.
// assumes: wr_en and rd_en are single-cycle, never both in one cycle.
`timescale 1ns/1ps
`include "tctp_cfg.svh"
module tctp_bus_dec (
   // host bus
   input  wire logic [`TCTP_ADDR_W-1:0] addr,
   input  wire logic                    wr_en,
   input  wire logic                    rd_en,
   input  wire logic [7:0]              wdata,
   // decoded strobes
   tctp_bus_if.dec                      bus
);

   // ===================================================================
   // strobe decode, unmapped writes fall through to nothing
   always_comb begin
      bus.wdata      = wdata;
      bus.rd_any     = rd_en;
      bus.wr_irq_clr = wr_en && (addr == `TCTP_OFF_IRQ_CLR);
      bus.wr_cmd     = wr_en && (addr == `TCTP_OFF_MODE_CMD);
      bus.wr_data[0] = wr_en && (addr == `TCTP_OFF_CTR_A);
      bus.wr_data[1] = wr_en && (addr == `TCTP_OFF_CTR_B);
      bus.wr_data[2] = wr_en && (addr == `TCTP_OFF_CTR_C);
      bus.rd_data[0] = rd_en && (addr == `TCTP_OFF_CTR_A);
      bus.rd_data[1] = rd_en && (addr == `TCTP_OFF_CTR_B);
      bus.rd_data[2] = rd_en && (addr == `TCTP_OFF_CTR_C);
   end

endmodule : tctp_bus_dec

// ===== hdl/tctp_top.sv
// tctp_top: host register port and three 16-bit counters.
// assumes: one clock ref_clk, synchronous reset srst, count ticks and
// gates synchronous to ref_clk, host makes single 8-bit accesses.
`timescale 1ns/1ps
`include "tctp_cfg.svh"

module tctp_top (
   // clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    srst,
   // host i/o bus
   input  wire logic [`TCTP_ADDR_W-1:0] addr,
   input  wire logic                    wr_en,
   input  wire logic                    rd_en,
   input  wire logic [7:0]              wdata,
   output logic      [7:0]              rdata,
   // counter pins
   input  wire logic [2:0]              cnt_tick,
   input  wire logic [2:0]              cnt_gate,
   output logic      [2:0]              cnt_out,
   // interrupt
   output logic                         irq
);

   // ===================================================================
   // functions

   // one step down in binary or in four bcd digits
   function automatic logic [15:0] tctp_dec(input logic [15:0] v,
                                            input logic        bcd);
      logic [15:0] r;
      logic        brw;
      r   = v;
      brw = 1'b1;
      if (!bcd) begin
         r = v - `TCTP_CNT_ONE;
      end else begin
         for (int d = 0; d < 4; d++) begin
            if (brw) begin
               if (v[d*4 +: 4] == 4'h0) begin
                  r[d*4 +: 4] = 4'h9;
               end else begin
                  r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
                  brw         = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction : tctp_dec

   // modes started by a gate rising edge rather than by the load
   function automatic logic tctp_hw_mode(input logic [2:0] m);
      return (m == `TCTP_M_ONE_SHOT) || (m == `TCTP_M_HW_STROBE);
   endfunction : tctp_hw_mode

   // modes whose output is a one-tick low strobe
   function automatic logic tctp_strobe_mode(input logic [2:0] m);
      return (m == `TCTP_M_SW_STROBE) || (m == `TCTP_M_HW_STROBE);
   endfunction : tctp_strobe_mode

   // capture the count unless a capture is already held
   function automatic tctp_pkg::tctp_ctr_t tctp_latch(
      input tctp_pkg::tctp_ctr_t c);
      tctp_pkg::tctp_ctr_t r;
      r = c;
      if (!c.latched) begin
         r.latch   = c.count;
         r.latched = 1'b1;
      end
      return r;
   endfunction : tctp_latch

   // ===================================================================
   // bus decode
   tctp_bus_if bus ();

   tctp_bus_dec u_dec (
      .addr  (addr),
      .wr_en (wr_en),
      .rd_en (rd_en),
      .wdata (wdata),
      .bus   (bus.dec)
   );

   // ===================================================================
   // state
   tctp_pkg::tctp_state_t st_r;
   tctp_pkg::tctp_state_t st_nxt;

   // ===================================================================
   // next state
   always_comb begin
      tctp_pkg::tctp_ctr_t c;
      logic [15:0]         dv;
      logic [15:0]         src;
      logic [1:0]          sel;
      logic [1:0]          acc;
      logic [2:0]          md;
      logic                trig;
      logic                run_ok;
      logic                loaded;
      c      = st_r.ctr[0];
      dv     = `TCTP_CNT_ZERO;
      src    = `TCTP_CNT_ZERO;
      trig   = 1'b0;
      run_ok = 1'b0;
      loaded = 1'b0;
      st_nxt = st_r;
      sel    = bus.wdata[`TCTP_SEL_MSB:`TCTP_SEL_LSB];
      acc    = bus.wdata[`TCTP_ACC_MSB:`TCTP_ACC_LSB];
      md     = bus.wdata[`TCTP_MODE_MSB:`TCTP_MODE_LSB];

      // unmapped reads answer zero
      if (bus.rd_any) begin
         st_nxt.rdata = `TCTP_BYTE_ZERO;
      end

      for (int i = 0; i < `TCTP_NUM_CTR; i++) begin
         c      = st_r.ctr[i];
         loaded = 1'b0;

         // gate edge for the hardware started modes
         trig     = cnt_gate[i] && !c.gate_q;
         c.gate_q = cnt_gate[i];

         // counting on each tick
         run_ok = c.run && (cnt_gate[i] || tctp_hw_mode(c.mode));
         if (cnt_tick[i]) begin
            if (tctp_strobe_mode(c.mode) && !c.out) begin
               c.out = 1'b1;
            end
            if (c.pend) begin
               c.count = c.reload;
               c.pend  = 1'b0;
               c.run   = 1'b1;
            end else if (run_ok) begin
               dv = tctp_dec(c.count, c.bcd);
               case (c.mode)
                  `TCTP_M_TERM_INT, `TCTP_M_ONE_SHOT: begin
                     c.count = dv;
                     if (dv == `TCTP_CNT_ZERO) begin
                        c.out = 1'b1;
                     end
                  end
                  `TCTP_M_RATE: begin
                     if (c.count == `TCTP_CNT_ONE) begin
                        c.count = c.reload;
                        c.out   = 1'b1;
                     end else begin
                        c.count = dv;
                        c.out   = (dv != `TCTP_CNT_ONE);
                     end
                  end
                  `TCTP_M_SQUARE: begin
                     if (c.count <= `TCTP_CNT_TWO) begin
                        c.count = c.reload;
                        c.out   = !c.out;
                     end else begin
                        c.count = tctp_dec(dv, c.bcd);
                     end
                  end
                  `TCTP_M_SW_STROBE, `TCTP_M_HW_STROBE: begin
                     c.count = dv;
                     if (dv == `TCTP_CNT_ZERO) begin
                        c.out = 1'b0;
                        c.run = 1'b0;
                     end
                  end
                  default: begin
                     c.count = dv;
                  end
               endcase
            end
         end

         // gate trigger restarts one-shot and hardware strobe
         if (trig && c.armed && tctp_hw_mode(c.mode)) begin
            c.count = c.reload;
            c.run   = 1'b1;
            if (c.mode == `TCTP_M_ONE_SHOT) begin
               c.out = 1'b0;
            end
         end

         // mode command
         if (bus.wr_cmd) begin
            if (sel == `TCTP_SEL_RBACK) begin
               if (!bus.wdata[`TCTP_RB_NCOUNT_BIT] &&
                   bus.wdata[`TCTP_RB_MASK_LSB + i]) begin
                  c = tctp_latch(c);
               end
            end else if (sel == i[1:0]) begin
               if (acc == `TCTP_ACC_LATCH) begin
                  c = tctp_latch(c);
               end else begin
                  c.access  = acc;
                  c.mode    = md;
                  c.bcd     = bus.wdata[`TCTP_BCD_BIT];
                  c.wr_hi   = 1'b0;
                  c.rd_hi   = 1'b0;
                  c.latched = 1'b0;
                  c.pend    = 1'b0;
                  c.armed   = 1'b0;
                  c.run     = 1'b0;
                  c.out     = (md != `TCTP_M_TERM_INT);
               end
            end
         end

         // data port write loads the start value
         if (bus.wr_data[i]) begin
            case (c.access)
               `TCTP_ACC_LOW: begin
                  c.reload = {`TCTP_BYTE_ZERO, bus.wdata};
                  loaded   = 1'b1;
               end
               `TCTP_ACC_HIGH: begin
                  c.reload = {bus.wdata, `TCTP_BYTE_ZERO};
                  loaded   = 1'b1;
               end
               `TCTP_ACC_BOTH: begin
                  if (!c.wr_hi) begin
                     c.wlow  = bus.wdata;
                     c.wr_hi = 1'b1;
                  end else begin
                     c.reload = {bus.wdata, c.wlow};
                     c.wr_hi  = 1'b0;
                     loaded   = 1'b1;
                  end
               end
               default: begin
               end
            endcase
            if (loaded) begin
               if (tctp_hw_mode(c.mode)) begin
                  c.armed = 1'b1;
               end else begin
                  c.pend = 1'b1;
               end
               if (c.mode == `TCTP_M_TERM_INT) begin
                  c.out = 1'b0;
               end
            end
         end

         // data port read returns captured or live count
         if (bus.rd_data[i]) begin
            src = c.latched ? c.latch : c.count;
            case (c.access)
               `TCTP_ACC_LOW: begin
                  st_nxt.rdata = src[7:0];
                  c.latched    = 1'b0;
               end
               `TCTP_ACC_HIGH: begin
                  st_nxt.rdata = src[15:8];
                  c.latched    = 1'b0;
               end
               `TCTP_ACC_BOTH: begin
                  if (!c.rd_hi) begin
                     st_nxt.rdata = src[7:0];
                     c.rd_hi      = 1'b1;
                  end else begin
                     st_nxt.rdata = src[15:8];
                     c.rd_hi      = 1'b0;
                     c.latched    = 1'b0;
                  end
               end
               default: begin
                  st_nxt.rdata = `TCTP_BYTE_ZERO;
               end
            endcase
         end

         st_nxt.ctr[i] = c;
      end

      // interrupt on counter c output falling, set wins over clear
      st_nxt.out_c_q = st_r.ctr[2].out;
      if (bus.wr_irq_clr) begin
         st_nxt.irq = 1'b0;
      end
      if (st_r.out_c_q && !st_r.ctr[2].out) begin
         st_nxt.irq = 1'b1;
      end
   end

   // ===================================================================
   // state register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_r <= '0;
         for (int i = 0; i < `TCTP_NUM_CTR; i++) begin
            st_r.ctr[i].access <= `TCTP_RST_ACC;
            st_r.ctr[i].mode   <= `TCTP_RST_MODE;
            st_r.ctr[i].out    <= 1'b1;
         end
         st_r.out_c_q <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ===================================================================
   // outputs straight from the state register
   assign rdata      = st_r.rdata;
   assign irq        = st_r.irq;
   assign cnt_out[0] = st_r.ctr[0].out;
   assign cnt_out[1] = st_r.ctr[1].out;
   assign cnt_out[2] = st_r.ctr[2].out;

endmodule : tctp_top

// ===== verification/tctp_top_assertions.sv
// tctp_top_assertions: port checks of the counter timer port.
// assumes: bound to tctp_top; one clock, synchronous srst.
`timescale 1ns/1ps
`include "tctp_cfg.svh"
module tctp_top_assertions (
   // clock and reset
   input wire logic                    ref_clk,
   input wire logic                    srst,
   // host bus
   input wire logic [`TCTP_ADDR_W-1:0] addr,
   input wire logic                    wr_en,
   input wire logic                    rd_en,
   input wire logic [7:0]              wdata,
   input wire logic [7:0]              rdata,
   // counter pins and interrupt
   input wire logic [2:0]              cnt_tick,
   input wire logic [2:0]              cnt_gate,
   input wire logic [2:0]              cnt_out,
   input wire logic                    irq
);
   // =================================================================
   // history of counter c output
   logic [2:0] oc_r;
   logic       clr;
   logic       quiet;
   logic       fell3;
   always_ff @(posedge ref_clk) begin
      oc_r <= {oc_r[1:0], cnt_out[2]};
   end
   // clear strobe, settled output, recent fall
   assign clr   = wr_en && (addr == `TCTP_OFF_IRQ_CLR);
   assign quiet = (cnt_out[2] == oc_r[0]) && (oc_r == {3{oc_r[0]}});
   assign fell3 = (oc_r[0] && !cnt_out[2]) || (oc_r[1] && !oc_r[0])
                  || (oc_r[2] && !oc_r[1]);

   // =================================================================
   // assertions
   chk_reset_values: assert property (@(posedge ref_clk)
      srst |=> rdata == 8'h00 && !irq && cnt_out == 3'h7)
      else $error("outputs wrong after reset");
   chk_rdata_holds: assert property (@(posedge ref_clk)
      disable iff (srst) !rd_en |=> $stable(rdata))
      else $error("read data changed without a read");
   chk_cmd_rd_zero: assert property (@(posedge ref_clk)
      disable iff (srst) rd_en && addr == `TCTP_OFF_MODE_CMD
      |=> rdata == 8'h00) else $error("mode register readable");
   chk_clr_rd_zero: assert property (@(posedge ref_clk)
      disable iff (srst) rd_en && addr == `TCTP_OFF_IRQ_CLR
      |=> rdata == 8'h00) else $error("clear strobe readable");
   chk_unmap_rd_zero: assert property (@(posedge ref_clk)
      disable iff (srst) rd_en && (addr < 4'h6 || addr > 4'hb
      || addr == 4'h7) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_irq_holds: assert property (@(posedge ref_clk)
      disable iff (srst) irq && !clr |=> irq)
      else $error("interrupt dropped without clear");
   chk_irq_sets: assert property (@(posedge ref_clk)
      disable iff (srst) $fell(cnt_out[2]) |-> ##[1:3] irq)
      else $error("low pulse did not raise interrupt");
   chk_irq_cause: assert property (@(posedge ref_clk)
      disable iff (srst) $rose(irq) |-> fell3)
      else $error("interrupt without low pulse");
   chk_irq_clears: assert property (@(posedge ref_clk)
      disable iff (srst) clr && quiet |=> !irq)
      else $error("clear strobe kept interrupt");

   // main scenarios reached
   cover property (@(posedge ref_clk) $rose(irq));
   cover property (@(posedge ref_clk) clr && irq);
   cover property (@(posedge ref_clk) rd_en && addr == `TCTP_OFF_CTR_C);
   cover property (@(posedge ref_clk) wr_en && addr ==
      `TCTP_OFF_MODE_CMD && wdata[7:6] == 2'h3);
endmodule : tctp_top_assertions

bind tctp_top tctp_top_assertions tctp_top_assertions_i (
   .ref_clk(ref_clk), .srst(srst), .addr(addr), .wr_en(wr_en),
   .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .cnt_tick(cnt_tick),
   .cnt_gate(cnt_gate), .cnt_out(cnt_out), .irq(irq));

// ===== verification/tctp_host_model.sv
// tctp_host_model: host side of the 8-bit i/o bus.
// assumes: the bench calls one task at a time.
`timescale 1ns/1ps
`include "tctp_cfg.svh"
module tctp_host_model (
   // clock
   input  wire logic        ref_clk,
   // host bus
   output logic      [3:0]  addr,
   output logic             wr_en,
   output logic             rd_en,
   output logic      [7:0]  wdata,
   input  wire logic [7:0]  rdata
);
   logic [7:0] mode_copy; // shadow of the write-only mode register

   // idle bus at time zero
   initial begin
      addr = 4'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      wdata = 8'h00;
      mode_copy = 8'h00;
   end

   // one 8-bit write; released lines show the inverse
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      if (a == `TCTP_OFF_MODE_CMD) mode_copy = v;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      addr <= ~a;
      wdata <= ~v;
   endtask : wr

   // one 8-bit read, data taken once settled
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      addr <= ~a;
      @(negedge ref_clk);
      v = rdata;
   endtask : rd

   // start-up sequence
   task automatic init();
      wr(`TCTP_OFF_MODE_CMD, 8'h34);
      wr(`TCTP_OFF_IRQ_CLR, 8'h00);
   endtask : init
endmodule : tctp_host_model

// ===== verification/triple_counter_timer_port_tb_top.sv
// triple_counter_timer_port_tb_top: random and corner tests.
// assumes: host model drives the bus, bench drives ticks and gates.
`timescale 1ns/1ps
`include "tctp_cfg.svh"
module triple_counter_timer_port_tb_top;
   // =================================================================
   // signals
   logic        ref_clk;
   logic        srst;
   logic [3:0]  addr;
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic [2:0]  cnt_tick;
   logic [2:0]  cnt_gate;
   logic [2:0]  cnt_out;
   logic        irq;
   logic [7:0]  d;
   logic [15:0] e;
   int          num_errors;
   int          compares;

   // clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   tctp_top tctp_top_i (.ref_clk(ref_clk), .srst(srst), .addr(addr),
      .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata),
      .cnt_tick(cnt_tick), .cnt_gate(cnt_gate), .cnt_out(cnt_out),
      .irq(irq));
   tctp_host_model tctp_host_model_i (.ref_clk(ref_clk), .addr(addr),
      .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata));

   // =================================================================
   // helpers
   task automatic end_sim();
      $display("compares=%0d errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp8

   task automatic cmp1(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp1

   task automatic w(input logic [3:0] a, input logic [7:0] v);
      tctp_host_model_i.wr(a, v);
   endtask : w

   task automatic tick(input int k, input int n);
      repeat (n) begin
         @(posedge ref_clk);
         cnt_tick[k] <= 1'b1;
         @(posedge ref_clk);
         cnt_tick[k] <= 1'b0;
      end
      repeat (3) @(negedge ref_clk);
   endtask : tick

   // bcd count down by one, 0000 wraps to 9999
   function automatic logic [15:0] bcd_dec(input logic [15:0] v);
      logic [15:0] x;
      x = v;
      for (int i = 0; i < 4; i++) begin
         if (x[i*4+:4] != 4'h0) begin
            x[i*4+:4] = x[i*4+:4] - 4'h1;
            return x;
         end
         x[i*4+:4] = 4'h9;
      end
      return x;
   endfunction : bcd_dec

   // read a counter by its byte access pattern
   task automatic rd_chk(input int k, input logic [1:0] acc,
                         input logic [15:0] x);
      logic [3:0] p;
      p = 4'(`TCTP_OFF_CTR_A + k);
      if (acc != `TCTP_ACC_HIGH) begin
         tctp_host_model_i.rd(p, d);
         cmp8(d, x[7:0]);
      end
      if (acc != `TCTP_ACC_LOW) begin
         tctp_host_model_i.rd(p, d);
         cmp8(d, x[15:8]);
      end
   endtask : rd_chk

   // mode 0 load with a stray byte first, count, latch, read back
   task automatic load_chk(input int k, input logic [1:0] acc,
                           input logic [15:0] v, input int n);
      logic [7:0] cmd;
      logic [3:0] p;
      cmd = {k[1:0], acc, 4'h0};
      p = 4'(`TCTP_OFF_CTR_A + k);
      w(`TCTP_OFF_MODE_CMD, cmd);
      w(p, 8'h5a);
      w(`TCTP_OFF_MODE_CMD, cmd);
      e = (acc == `TCTP_ACC_LOW) ? {8'h00, v[7:0]} :
          (acc == `TCTP_ACC_HIGH) ? {v[15:8], 8'h00} : v;
      if (acc != `TCTP_ACC_HIGH) w(p, e[7:0]);
      if (acc != `TCTP_ACC_LOW) w(p, e[15:8]);
      tick(k, n + 1);
      e = e - 16'(n);
      rd_chk(k, acc, e);
      cmp1(cnt_out[k], 1'b0);
      // full pattern latches by read-back, the others by latch command
      if (acc == `TCTP_ACC_BOTH)
         w(`TCTP_OFF_MODE_CMD, {2'h3, 2'h0, 3'(1 << k), 1'b0});
      else
         w(`TCTP_OFF_MODE_CMD, {k[1:0], 6'h00});
      tick(k, 2);
      rd_chk(k, acc, e);
      rd_chk(k, acc, e - 16'h0002);
   endtask : load_chk

   // =================================================================
   // watchdog
   initial begin
      #500000;
      num_errors++;
      end_sim();
   end

   // main sequence
   initial begin
      num_errors = 0;
      compares = 0;
      srst = 1'b1;
      cnt_tick = 3'h0;
      cnt_gate = 3'h7;
      void'($urandom(32'hbda5));
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      tctp_host_model_i.init();
      repeat (3) @(negedge ref_clk);
      cmp1(irq, 1'b0);
      // write-only and unmapped offsets read as zero
      for (int a = 0; a < 16; a++) begin
         if (a < 8 || a > 10) begin
            tctp_host_model_i.rd(4'(a), d);
            cmp8(d, 8'h00);
         end
      end
      // every counter with every byte access pattern
      for (int i = 0; i < 9; i++) begin
         e = {8'($urandom_range(255, 1)), 8'($urandom_range(255, 16))};
         load_chk(i % 3, 2'(i / 3 + 1), e, $urandom_range(7, 0));
      end
      // mode 0 output rises when the count reaches zero
      w(`TCTP_OFF_MODE_CMD, 8'h50);
      w(`TCTP_OFF_CTR_B, 8'h02);
      tick(1, 2);
      cmp1(cnt_out[1], 1'b0);
      tick(1, 1);
      cmp1(cnt_out[1], 1'b1);
      // every mode code; gate-level modes load and count, square by two
      for (int m = 0; m < 6; m++) begin
         w(`TCTP_OFF_MODE_CMD, {4'h7, 3'(m), 1'b0});
         if (m != 1 && m != 5) begin
            w(`TCTP_OFF_CTR_B, 8'h40);
            w(`TCTP_OFF_CTR_B, 8'h01);
            tick(1, 2);
            rd_chk(1, 2'h3, (m == 3) ? 16'h013e : 16'h013f);
         end
      end
      // one-shot on counter a starts on a gate rise, ends at zero
      w(`TCTP_OFF_MODE_CMD, 8'h12);
      w(`TCTP_OFF_CTR_A, 8'h03);
      @(posedge ref_clk) cnt_gate[0] <= 1'b0;
      @(posedge ref_clk) cnt_gate[0] <= 1'b1;
      tick(0, 2);
      cmp1(cnt_out[0], 1'b0);
      tick(0, 1);
      cmp1(cnt_out[0], 1'b1);
      // bcd borrow and wrap
      for (int i = 0; i < 2; i++) begin
         e = (i == 1) ? 16'h0100 : 16'h0000;
         w(`TCTP_OFF_MODE_CMD, 8'h31);
         w(`TCTP_OFF_CTR_A, e[7:0]);
         w(`TCTP_OFF_CTR_A, e[15:8]);
         tick(0, 3);
         rd_chk(0, 2'h3, bcd_dec(bcd_dec(e)));
      end
      // interrupt from a rate generator pulse on counter c
      w(`TCTP_OFF_IRQ_CLR, 8'h00);
      repeat (3) @(negedge ref_clk);
      cmp1(irq, 1'b0);
      w(`TCTP_OFF_MODE_CMD, 8'hb4);
      w(`TCTP_OFF_CTR_C, 8'h03);
      w(`TCTP_OFF_CTR_C, 8'h00);
      tick(2, 4);
      cmp1(irq, 1'b1);
      repeat (8) @(negedge ref_clk);
      cmp1(irq, 1'b1);
      w(`TCTP_OFF_IRQ_CLR, 8'($urandom));
      repeat (2) @(negedge ref_clk);
      cmp1(irq, 1'b0);
      end_sim();
   end
endmodule : triple_counter_timer_port_tb_top
